// File: verilog/aiu_regs.vh
`ifndef AIU_REGS_VH
`define AIU_REGS_VH
// Register word addresses on the four-bit address bus.
`define AIU_ADDR_MASK_TRIG 4'h9
`define AIU_ADDR_FLAGS 4'ha
// Field positions inside the mask-and-triggers register.
`define AIU_ENA_LO 0
`define AIU_ENA_HI 7
`define AIU_MATCH_LO 8
`define AIU_MATCH_HI 10
`define AIU_FILL_LO 11
`define AIU_FILL_HI 15
// Reset values.
`define AIU_MASK_RESET 16'h0000
`define AIU_FLAGS_RESET 8'h00
// Source numbers.
`define AIU_SRC_LIMIT 0
`define AIU_SRC_MATCH 1
`define AIU_SRC_FILL 2
`define AIU_SRC_SHORTZ 3
`define AIU_SRC_FULLCAL 4
`define AIU_SRC_PAUSE 5
`define AIU_SRC_LOWSUP 6
`define AIU_SRC_WAKE 7
// Standby exit settling time in microseconds and the clock rate in MHz.
`define AIU_WAKE_US 10000
`define AIU_CLK_MHZ 100
// Diagnostic channel codes and routing selectors.
`define AIU_CH_REFOUT 3'h0
`define AIU_CH_REFPAIR 3'h1
`define AIU_ROUTE_IN 3'h0
`define AIU_ROUTE_GND 3'h1
`define AIU_ROUTE_REFOUT 3'h2
`define AIU_ROUTE_REFPOS 3'h3
`define AIU_ROUTE_REFNEG 3'h4
`endif

// File: verilog/aiu_sync_bank.v
// Two-stage synchroniser bank for asynchronous status inputs.
module aiu_sync_bank #(
    parameter WIDTH = 2
) (
    input wire clk_sys,
    input wire reset_n,
    input wire [WIDTH-1:0] asyncIn,
    output reg [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] stageOne;

    // First stage feeds only the second stage.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stageOne <= {WIDTH{1'b0}};
            syncOut <= {WIDTH{1'b0}};
        end else begin
            stageOne <= asyncIn;
            syncOut <= stageOne;
        end
    end
endmodule // aiu_sync_bank

// File: verilog/aiu_interrupt_unit.v
`include "aiu_regs.vh"
module aiu_interrupt_unit #(
    parameter WAKE_CYCLES = `AIU_WAKE_US * `AIU_CLK_MHZ
) (
    input wire clk_sys,
    input wire reset_n,
    input wire regSelect,
    input wire regRead,
    input wire regWrite,
    input wire [3:0] regAddr,
    input wire [15:0] regWdata,
    output reg [15:0] regRdata,
    output reg intOut_n,
    input wire seqReset,
    input wire seqStart,
    input wire seqFetch,
    input wire [2:0] seqAddr,
    input wire seqFetchPause,
    input wire wdCompare,
    input wire wdLimitSel,
    input wire wdDirAbove,
    input wire wdInAbove,
    input wire wdInBelow,
    input wire [4:0] fifoCount,
    input wire shortZeroDone,
    input wire fullCalDone,
    input wire lowSupplyRaw,
    input wire standbyExit,
    input wire diagMode,
    input wire [2:0] chanCode,
    output reg [15:0] limitStatus,
    output reg [2:0] mux_positive_out,
    output reg [2:0] mux_negative_out
);
    // The settling count is cut to the timer width on purpose; the default fits easily.
    localparam [31:0] WAKE_FULL = WAKE_CYCLES;
    localparam [23:0] WAKE_COUNT = WAKE_FULL[23:0];
    // The settling timer needs only an idle and a waiting state.
    localparam WAKE_IDLE = 1'b0;
    localparam WAKE_WAIT = 1'b1;

    // Registers, then the combinational helpers that feed them; wakeDone among them is also a register.
    reg [15:0] maskTrig;
    reg [7:0] flags;
    reg [4:0] lastFifo;
    reg zeroSeen;
    reg wakeState;
    reg [23:0] wakeTimer;
    reg [7:0] next_flags;
    reg [7:0] events;
    reg wakeDone;
    reg limitHit;
    // Bus decode and the synchronised detector level.
    wire supplySync;
    wire isWrite;
    wire statusRead;

    // Detector level arrives from the analog side, so it is synchronised first.
    aiu_sync_bank #(
        .WIDTH(1)
    ) supplySyncBank (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .asyncIn(lowSupplyRaw),
        .syncOut(supplySync)
    );

    // Limit comparison result honouring the direction bit.
    function crossed;
        input dirAbove;
        input above;
        input below;
        begin
            crossed = dirAbove ? above : below;
        end
    endfunction

    assign isWrite = regSelect && regWrite;
    assign statusRead = regSelect && regRead && (regAddr == `AIU_ADDR_FLAGS);

    // Event collection for all eight sources.
    always @* begin
        limitHit = wdCompare && crossed(wdDirAbove, wdInAbove, wdInBelow);
        events = 8'h00;
        events[`AIU_SRC_LIMIT] = limitHit;
        // A zero match value ignores the first pass over instruction zero.
        events[`AIU_SRC_MATCH] = seqFetch
            && (seqAddr == maskTrig[`AIU_MATCH_HI:`AIU_MATCH_LO])
            && !(seqAddr == 3'h0 && !zeroSeen);
        // Fires only on the cycle the count arrives at the trigger level.
        events[`AIU_SRC_FILL] = (fifoCount == maskTrig[`AIU_FILL_HI:`AIU_FILL_LO])
            && (fifoCount != lastFifo)
            && (maskTrig[`AIU_FILL_HI:`AIU_FILL_LO] != 5'h00);
        events[`AIU_SRC_SHORTZ] = shortZeroDone;
        events[`AIU_SRC_FULLCAL] = fullCalDone;
        events[`AIU_SRC_PAUSE] = seqFetch && seqFetchPause;
        events[`AIU_SRC_LOWSUP] = supplySync;
        events[`AIU_SRC_WAKE] = wakeDone;
    end

    // A read clears the flags, but an event in the same cycle still lands.
    always @* begin
        if (statusRead || seqReset) begin
            next_flags = events;
        end else begin
            next_flags = flags | events;
        end
    end

    // Flag, mask and bookkeeping registers.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            flags <= `AIU_FLAGS_RESET;
            maskTrig <= `AIU_MASK_RESET;
            lastFifo <= 5'h00;
            zeroSeen <= 1'b0;
            limitStatus <= 16'h0000;
        end else begin
            flags <= next_flags;
            lastFifo <= fifoCount;
            if (isWrite && regAddr == `AIU_ADDR_MASK_TRIG) begin
                maskTrig <= regWdata;
            end
            // The first-pass memory clears on sequencer reset or start and sets on a fetch of instruction zero.
            if (seqReset || seqStart) begin
                zeroSeen <= 1'b0;
            end else if (seqFetch && seqAddr == 3'h0) begin
                zeroSeen <= 1'b1;
            end
            if (seqReset) begin
                limitStatus <= 16'h0000;
            end else if (limitHit) begin
                limitStatus[{wdLimitSel, seqAddr}] <= 1'b1;
            end
        end
    end

    // Settling timer after standby exit.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wakeState <= WAKE_IDLE;
            wakeTimer <= 24'h000000;
            wakeDone <= 1'b0;
        end else begin
            wakeDone <= 1'b0;
            case (wakeState)
                WAKE_IDLE: begin
                    if (standbyExit) begin
                        wakeState <= WAKE_WAIT;
                        wakeTimer <= WAKE_COUNT;
                    end
                end
                WAKE_WAIT: begin
                    if (wakeTimer <= 24'h000001) begin
                        wakeState <= WAKE_IDLE;
                        wakeDone <= 1'b1;
                    end else begin
                        wakeTimer <= wakeTimer - 24'h000001;
                    end
                end
                default: begin
                    wakeState <= WAKE_IDLE;
                end
            endcase
        end
    end

    // Pin and read data are registered so the pin never glitches.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            intOut_n <= 1'b1;
            regRdata <= 16'h0000;
        end else begin
            // Uses next flags so the pin tracks the flag register exactly.
            intOut_n <= ~|(next_flags & maskTrig[`AIU_ENA_HI:`AIU_ENA_LO]);
            if (regSelect && regRead && regAddr == `AIU_ADDR_MASK_TRIG) begin
                regRdata <= maskTrig;
            end else if (statusRead) begin
                regRdata <= {fifoCount, seqAddr, flags};
            end else begin
                regRdata <= 16'h0000;
            end
        end
    end

    // Input multiplexer routing; diagnostics only override codes 000 and 001.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mux_positive_out <= `AIU_ROUTE_IN;
            mux_negative_out <= `AIU_ROUTE_GND;
        end else if (diagMode && chanCode == `AIU_CH_REFOUT) begin
            mux_positive_out <= `AIU_ROUTE_REFOUT;
            mux_negative_out <= `AIU_ROUTE_GND;
        end else if (diagMode && chanCode == `AIU_CH_REFPAIR) begin
            mux_positive_out <= `AIU_ROUTE_REFPOS;
            mux_negative_out <= `AIU_ROUTE_REFNEG;
        end else begin
            mux_positive_out <= `AIU_ROUTE_IN;
            mux_negative_out <= (chanCode == `AIU_CH_REFOUT) ? `AIU_ROUTE_GND : `AIU_ROUTE_IN;
        end
    end
endmodule // aiu_interrupt_unit

// File: verif/aiu_irq_properties.sv
module aiu_irq_properties (
    input wire clk_sys,
    input wire reset_n,
    input wire regSelect,
    input wire regRead,
    input wire regWrite,
    input wire [3:0] regAddr,
    input wire [15:0] regWdata,
    input wire [15:0] regRdata,
    input wire intOut_n,
    input wire seqReset,
    input wire [2:0] seqAddr,
    input wire [4:0] fifoCount,
    input wire shortZeroDone,
    input wire diagMode,
    input wire [2:0] chanCode,
    input wire [2:0] mux_positive_out,
    input wire [2:0] mux_negative_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wire rdA = regSelect && regRead && regAddr == 4'ha;
    wire w9 = regSelect && regWrite && regAddr == 4'h9;
    reg [15:0] mask;
    // Shadow of the mask register, since the pin checks need it and the body is hidden.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            mask <= 16'h0000;
        else if (w9)
            mask <= regWdata;
    end
    status_fields_a: assert property (rdA |=>
        regRdata[15:8] == {$past(fifoCount), $past(seqAddr)}) else $error("bad status fields");
    mask_readback_a: assert property (regSelect && regRead && regAddr == 4'h9 |=>
        regRdata == $past(mask)) else $error("bad mask readback");
    quiet_pin_a: assert property (mask[7:0] == 8'h00 && !w9 |=> intOut_n)
        else $error("pin low with all masked");
    shortz_pin_a: assert property (shortZeroDone && mask[3] && !w9 && !seqReset |=>
        !intOut_n) else $error("pin missed event");
    pin_release_a: assert property ($rose(intOut_n) |->
        $past(rdA || seqReset) || $past(w9, 2)) else $error("pin released without cause");
    shortz_flag_a: assert property (shortZeroDone && !seqReset ##1 rdA && !seqReset |=>
        regRdata[3]) else $error("flag not set");
    diag_ref_a: assert property (diagMode && chanCode == 3'h0 |=>
        mux_positive_out == 3'h2 && mux_negative_out == 3'h1) else $error("bad diag route");
    diag_pair_a: assert property (diagMode && chanCode == 3'h1 |=>
        mux_positive_out == 3'h3 && mux_negative_out == 3'h4) else $error("bad diag pair");
    norm_route_a: assert property (!diagMode || chanCode > 3'h1 |=> mux_positive_out == 3'h0
        && mux_negative_out == {2'h0, $past(chanCode) == 3'h0}) else $error("bad route");
endmodule // aiu_irq_properties
bind aiu_interrupt_unit aiu_irq_properties chk_u (.*);

// File: verif/aiu_host_model.sv
module aiu_host_model (
    input wire clk_sys,
    input wire [15:0] regRdata,
    output logic regSelect,
    output logic regRead,
    output logic regWrite,
    output logic [3:0] regAddr,
    output logic [15:0] regWdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {regSelect, regRead, regWrite, regAddr, regWdata} = '0;
    // Reads launch and release on falling edges; on release select and read drop and the address is inverted, not held.
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(negedge clk_sys);
        {regSelect, regRead, regAddr} = {2'b11, a};
        @(negedge clk_sys);
        {regSelect, regRead, regAddr} = {2'b00, ~a};
        d = regRdata;
    endtask
    // A mask write is always followed by a status read to flush stray flags.
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        logic [15:0] junk;
        @(negedge clk_sys);
        {regSelect, regWrite, regAddr, regWdata} = {2'b11, a, v};
        @(negedge clk_sys);
        {regSelect, regWrite, regAddr, regWdata} = {2'b00, ~a, ~v};
        if (a == 4'h9)
            rd(4'ha, junk);
    endtask
endmodule // aiu_host_model

// File: verif/aiu_tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [24:0] STIM [9] = '{25'h7b0, 25'h1c, 25'h5000, 25'h20000, 25'h40000,
        25'h44, 25'h80000, 25'h100000, 25'h890};
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [24:0] ev = '0;
    logic [15:0] seed = 16'h29d7;
    logic [15:0] got;
    int num_errors = 0;
    int compares = 0;
    wire regSelect, regRead, regWrite, intOut_n;
    wire [3:0] regAddr;
    wire [15:0] regWdata, regRdata, limitStatus;
    aiu_host_model host_u (.*);
    aiu_interrupt_unit #(.WAKE_CYCLES(20)) dut_u (.*, .seqReset(ev[0]), .seqStart(ev[1]),
        .seqFetch(ev[2]), .seqAddr(ev[5:3]), .seqFetchPause(ev[6]), .wdCompare(ev[7]),
        .wdLimitSel(ev[8]), .wdDirAbove(ev[9]), .wdInAbove(ev[10]), .wdInBelow(ev[11]),
        .fifoCount(ev[16:12]), .shortZeroDone(ev[17]), .fullCalDone(ev[18]),
        .lowSupplyRaw(ev[19]), .standbyExit(ev[20]), .diagMode(ev[21]),
        .chanCode(ev[24:22]), .mux_positive_out(), .mux_negative_out());
    function automatic logic [15:0] nx(input logic [15:0] x);
        return {1'b0, x[15:1]} ^ (x[0] ? 16'hb400 : 16'h0000);
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic chk_pin(input logic g, input logic e);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t pin got %b want %b", $time, g, e);
        end
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic pulse(input logic [24:0] v);
        @(negedge clk_sys) ev = v;
        @(negedge clk_sys) ev = '0;
    endtask
    initial forever #5 clk_sys = ~clk_sys;
    // The run needs about sixteen hundred cycles, so this limit only trips on a hang.
    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end
    // Directed corners first, then a random soak that feeds the checker.
    initial begin
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys) reset_n = 1'b1;
        ev = 25'h11028;
        host_u.rd(4'ha, got);
        chk(got, 16'h8d00);
        ev = '0;
        host_u.rd(4'h3, got);
        chk(got, 16'h0000);
        host_u.wr(4'h9, 16'ha5c3);
        host_u.wr(4'ha, 16'hffff);
        host_u.rd(4'h9, got);
        chk(got, 16'ha5c3);
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 9; k++) begin
                host_u.wr(4'h9, {8'h2b, m ? 8'h00 : 8'h01 << k % 8});
                pulse(STIM[k]);
                repeat (25) @(negedge clk_sys);
                chk_pin(intOut_n, m[0]);
                host_u.rd(4'ha, got);
                chk(got, 16'h0001 << k % 8);
                chk_pin(intOut_n, 1'b1);
                host_u.rd(4'ha, got);
                chk(got, 16'h0000);
                chk(limitStatus, k == 0 ? 16'h4000 : k == 8 ? 16'h0004 : 16'h0000);
                pulse(25'h1);
            end
        end
        host_u.wr(4'h9, 16'hf802);
        pulse(25'h1);
        pulse(25'h2);
        pulse(25'h4);
        host_u.rd(4'ha, got);
        chk(got, 16'h0000);
        pulse(25'h4);
        host_u.rd(4'ha, got);
        chk(got, 16'h0002);
        repeat (400) begin
            @(negedge clk_sys);
            seed = nx(seed);
            ev = {seed[8:1], &seed[2:0], nx(seed)};
            if (seed[3:0] == 4'h0)
                host_u.wr(4'h9, {seed[15:11] | 5'h01, seed[10:0]});
            else if (seed[4])
                host_u.rd(seed[8:5], got);
        end
        end_of_test();
    end
endmodule // tb
